// ### rftrb_regs.sv
// Peripheral register banks with RF pin timing, rate buffer access and control bits.
// How it works
// [RULE1] Demodulator and receive-enable pin events compare 9-bit times against receive counter.
// [RULE2] Demodulator upper bits: on 01 base, 00 handset; off 10 base, 01 handset.
// [RULE3] Software writes time modulo 128 minus one; timing fields read zero.
// [RULE4] Timing writes take effect immediately.
// [RULE5] Transmit disabled and full search keeps receive power on continuously.
// [RULE6] Receive polarity 0: rf receive pin low-active, receive enable high-active.
// [RULE7] Transmit pin timed on transmit counter, fixed upper bits, polarity bit.
// [RULE8] Transmit disabled holds transmit pin inactive.
// [RULE9] RF receive pin events use transmit counter.
// [RULE10] RF receive upper bits: on 00 base, 01 handset; off 01/10.
// [RULE11] Receive index ranges 0 to 23h; index register reads zero.
// [RULE12] Bit 14 enables receive auto-increment, bit 6 transmit auto-increment.
// [RULE13] Enabled auto-increment advances receive index after each data port read below 23h, transmit index after each write while the FIFO has room.
// [RULE14] Data writes decode by transmit index: data, voice init, marker, modulator.
// [RULE15] Data port read returns receive buffer nibble at receive index.
// [RULE16] Modulator words are two's complement, 62.5 Hz per bit.
// [RULE17] Symbol error readable as bits 23..8 and bits 7..0.
// [RULE18] Sync slot write loads loop value; read returns upper error bits.
// [RULE19] Spare slots read zero; writes ignored.
// [RULE20] Bit 10 enables frame start interrupt, reset zero.
// [RULE21] Bits 9 and 8 enable external interrupts zero and two.
// [RULE22] Bits 7..4 enable port zero wake-up, active low, only for inputs.
// [RULE23] Wake inputs debounced, bit-clock synchronised, stretched one bit minimum.
// [RULE24] Bits 3..0 drive transmit power DAC.
module rftrb_regs
  import rftrb_pkg::*;
#(
  parameter int BIT_DIV = 24,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [1:0] bank_i,
  input wire logic [2:0] slot_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  input wire logic handset_i,
  input wire logic tx_enable_i,
  input wire logic full_search_i,
  input wire logic [8:0] rx_count_i,
  input wire logic [8:0] tx_count_i,
  output logic receive_enable_pin_o,
  output logic rf_receive_pin_o,
  output logic rf_transmit_pin_o,
  input wire logic [23:0] symbol_error_i,
  output logic [15:0] sync_loop_o,
  output logic sync_loop_load_o,
  input wire logic [5:0] voice_rx_idx_i,
  output logic [3:0] voice_rx_nibble_o,
  output logic [5:0] voice_tx_index_init_o,
  output logic [5:0] voice_rx_index_init_o,
  output logic [15:0] nibble_marker_o,
  output logic [15:0] modulator_frequency_words_o [11],
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [5:0] wr_idx_o,
  output logic [15:0] wr_data_o,
  output logic wr_ready_o,
  input wire logic [3:0] rx_nibble_i,
  input wire logic rx_nibble_valid_i,
  input wire logic [5:0] rx_nibble_idx_i,
  output logic frame_start_irq_on_o,
  output logic ext_irq_zero_on_o,
  output logic ext_irq_two_on_o,
  input wire logic [3:0] port_zero_n_i,
  input wire logic [3:0] port_zero_dir_i,
  output logic wake_o,
  output logic [3:0] transmit_level_dac_o
);
  if (BIT_DIV < 2 || FIFO_DEPTH < 2) begin : g_bad_param
    $error("Bit divider and FIFO depth must be at least two.");
  end

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic hit_demod;
  logic hit_txpin;
  logic hit_rxpin;
  logic hit_index;
  logic hit_port;
  logic hit_sync;
  logic hit_ctrl;
  logic hit_errlo;
  assign hit_demod = bank_i == BANK2 && slot_i == SLOT_DEMOD;
  assign hit_txpin = bank_i == BANK2 && slot_i == SLOT_TXPIN;
  assign hit_rxpin = bank_i == BANK0 && slot_i == SLOT_RXPIN;
  assign hit_index = bank_i == BANK1 && slot_i == SLOT_INDEX;
  assign hit_port = bank_i == BANK1 && slot_i == SLOT_PORT;
  assign hit_sync = bank_i == BANK1 && slot_i == SLOT_SYNC;
  assign hit_ctrl = bank_i == BANK1 && slot_i == SLOT_CTRL;
  assign hit_errlo = bank_i == BANK0 && slot_i == SLOT_ERRLO;

  // ----------------------------------------
  // Timing windows
  // ----------------------------------------
  rftrb_window_s demod_w;
  rftrb_window_s txpin_w;
  rftrb_window_s rxpin_w;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      demod_w <= '0;
      txpin_w <= '0;
      rxpin_w <= '0;
    end else if (wr_i) begin
      if (hit_demod) begin
        demod_w <= {wdata_i[POL_BIT], wdata_i[ON_LSB+:7], wdata_i[6:0]}; // see [RULE4]
      end
      if (hit_txpin) begin
        txpin_w <= {wdata_i[POL_BIT], wdata_i[ON_LSB+:7], wdata_i[6:0]}; // see [RULE4]
      end
      if (hit_rxpin) begin
        rxpin_w <= {wdata_i[POL_BIT], wdata_i[ON_LSB+:7], wdata_i[6:0]}; // see [RULE4]
      end
    end
  end

  // Nine-bit event times: fixed upper pair above the seven programmed bits.
  logic [8:0] demod_on;
  logic [8:0] demod_off;
  logic [8:0] tx_on;
  logic [8:0] tx_off;
  logic [8:0] rx_on;
  logic [8:0] rx_off;
  assign demod_on = {handset_i ? DEMOD_ON_HAND : DEMOD_ON_BASE, demod_w.on_t}; // see [RULE2]
  assign demod_off = {handset_i ? DEMOD_OFF_HAND : DEMOD_OFF_BASE, demod_w.off_t}; // see [RULE2]
  assign tx_on = {handset_i ? PIN_ON_HAND : PIN_ON_BASE, txpin_w.on_t}; // see [RULE7]
  assign tx_off = {handset_i ? PIN_OFF_HAND : PIN_OFF_BASE, txpin_w.off_t}; // see [RULE7]
  assign rx_on = {handset_i ? PIN_ON_HAND : PIN_ON_BASE, rxpin_w.on_t}; // see [RULE10]
  assign rx_off = {handset_i ? PIN_OFF_HAND : PIN_OFF_BASE, rxpin_w.off_t}; // see [RULE10]

  logic demod_act;
  logic tx_act;
  logic rx_act;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      demod_act <= 1'b0;
    end else if (rx_count_i == demod_on) begin
      demod_act <= 1'b1; // see [RULE1]
    end else if (rx_count_i == demod_off) begin
      demod_act <= 1'b0; // see [RULE1]
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tx_act <= 1'b0;
    end else if (tx_count_i == tx_on) begin
      tx_act <= 1'b1; // see [RULE7]
    end else if (tx_count_i == tx_off) begin
      tx_act <= 1'b0; // see [RULE7]
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rx_act <= 1'b0;
    end else if (tx_count_i == rx_on) begin
      rx_act <= 1'b1; // see [RULE9]
    end else if (tx_count_i == rx_off) begin
      rx_act <= 1'b0; // see [RULE9]
    end
  end

  logic rx_power;
  logic tx_power;
  assign rx_power = (!tx_enable_i && full_search_i) || demod_act; // see [RULE5]
  assign tx_power = tx_enable_i && tx_act; // see [RULE8]
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      receive_enable_pin_o <= 1'b0;
      rf_receive_pin_o <= 1'b1;
      rf_transmit_pin_o <= 1'b0;
    end else begin
      receive_enable_pin_o <= rx_power ^ rxpin_w.pol; // see [RULE6]
      rf_receive_pin_o <= ((!tx_enable_i && full_search_i) || rx_act) ~^ rxpin_w.pol; // see [RULE6]
      rf_transmit_pin_o <= tx_power ^ txpin_w.pol; // see [RULE7]
    end
  end

  // ----------------------------------------
  // Rate buffer indices and storage
  // ----------------------------------------
  logic rx_inc;
  logic tx_inc;
  logic [5:0] rx_idx;
  logic [5:0] tx_idx;
  logic [3:0] rx_buf [36];
  logic port_acc;
  assign port_acc = hit_port && (wr_i || rd_i);
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rx_inc <= 1'b0;
      tx_inc <= 1'b0;
      rx_idx <= '0;
      tx_idx <= '0;
    end else if (wr_i && hit_index) begin
      rx_inc <= wdata_i[RX_INC_BIT]; // see [RULE12]
      tx_inc <= wdata_i[TX_INC_BIT]; // see [RULE12]
      rx_idx <= wdata_i[RX_IDX_LSB+:6]; // see [RULE11]
      tx_idx <= wdata_i[5:0];
    end else if (port_acc) begin
      if (rx_inc && rd_i && rx_idx < IDX_BUF_LAST) begin
        rx_idx <= rx_idx + 6'h01; // see [RULE13]
      end
      if (tx_inc && wr_i && wr_ready_o) begin
        tx_idx <= tx_idx + 6'h01; // see [RULE13]
      end
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (rx_nibble_valid_i && rx_nibble_idx_i <= IDX_BUF_LAST) begin
      rx_buf[rx_nibble_idx_i] <= rx_nibble_i;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      voice_rx_nibble_o <= '0;
    end else if (voice_rx_idx_i <= IDX_BUF_LAST) begin
      voice_rx_nibble_o <= rx_buf[voice_rx_idx_i];
    end
  end

  // Writes to buffer data go out through the FIFO; settings are kept here.
  logic buf_wr;
  rftrb_wr_s fifo_in;
  rftrb_wr_s fifo_out;
  assign buf_wr = wr_i && hit_port && tx_idx <= IDX_BUF_LAST; // see [RULE14]
  assign fifo_in = {tx_idx, wdata_i};
  assign wr_idx_o = fifo_out.idx;
  assign wr_data_o = fifo_out.data;
  rftrb_fifo #(.WIDTH($bits(rftrb_wr_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .in_valid_i(buf_wr),
    .in_ready_o(wr_ready_o),
    .in_data_i(fifo_in),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o(fifo_out)
  );
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      voice_tx_index_init_o <= '0;
      voice_rx_index_init_o <= '0;
      nibble_marker_o <= '0;
      for (int i = 0; i < 11; i++) begin
        modulator_frequency_words_o[i] <= '0;
      end
    end else if (wr_i && hit_port) begin
      if (tx_idx == IDX_VOICE) begin
        voice_tx_index_init_o <= wdata_i[13:8]; // see [RULE14]
        voice_rx_index_init_o <= wdata_i[5:0];
      end else if (tx_idx >= IDX_MARK_LO && tx_idx <= IDX_MARK_HI) begin
        nibble_marker_o <= wdata_i; // see [RULE14]
      end else if (tx_idx >= IDX_MOD_LO && tx_idx <= IDX_MOD_HI) begin
        // Kept as raw two's complement, 62.5 Hz per step.
        modulator_frequency_words_o[4'(tx_idx - IDX_MOD_LO)] <= wdata_i; // see [RULE16]
      end
    end
  end

  // ----------------------------------------
  // Symbol synchroniser loop
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sync_loop_o <= '0;
      sync_loop_load_o <= 1'b0;
    end else begin
      sync_loop_load_o <= wr_i && hit_sync; // see [RULE18]
      if (wr_i && hit_sync) begin
        sync_loop_o <= wdata_i; // see [RULE18]
      end
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic [10:0] ctrl;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctrl <= '0; // see [RULE20]
    end else if (wr_i && hit_ctrl) begin
      ctrl <= wdata_i[10:0]; // see [RULE21]
    end
  end
  assign frame_start_irq_on_o = ctrl[FS_EN_BIT]; // see [RULE20]
  assign ext_irq_zero_on_o = ctrl[IRQ0_EN_BIT]; // see [RULE21]
  assign ext_irq_two_on_o = ctrl[IRQ2_EN_BIT]; // see [RULE21]
  assign transmit_level_dac_o = ctrl[3:0]; // see [RULE24]

  // ----------------------------------------
  // Wake-up inputs
  // ----------------------------------------
  logic [$clog2(BIT_DIV)-1:0] div_cnt;
  logic bit_tick;
  assign bit_tick = div_cnt == ($clog2(BIT_DIV))'(BIT_DIV - 1);
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || bit_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  logic [3:0] wk_s1;
  logic [3:0] wk_s2;
  logic [3:0] wk_raw;
  logic [DEBOUNCE_BITS-1:0] wk_hist [4];
  logic [3:0] wk_q;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wk_s1 <= 4'hF;
      wk_s2 <= 4'hF;
    end else begin
      wk_s1 <= port_zero_n_i;
      wk_s2 <= wk_s1;
    end
  end
  assign wk_raw = ~wk_s2 & ~port_zero_dir_i & ctrl[WAKE_LSB+:4]; // see [RULE22]
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wk_q <= '0;
      for (int i = 0; i < 4; i++) begin
        wk_hist[i] <= '0;
      end
    end else if (bit_tick) begin
      for (int i = 0; i < 4; i++) begin
        wk_hist[i] <= {wk_hist[i][DEBOUNCE_BITS-2:0], wk_raw[i]};
        // Held steady across the history: a single bit-tick sample lasts one full bit.
        if (&wk_hist[i]) begin
          wk_q[i] <= 1'b1; // see [RULE23]
        end else if (~|wk_hist[i]) begin
          wk_q[i] <= 1'b0;
        end
      end
    end
  end
  assign wake_o = |wk_q; // see [RULE23]

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= '0; // see [RULE3]
      if (hit_port && rx_idx <= IDX_BUF_LAST) begin
        rdata_o <= {12'h000, rx_buf[rx_idx]}; // see [RULE15]
      end else if (hit_sync) begin
        rdata_o <= symbol_error_i[23:8]; // see [RULE17]
      end else if (hit_errlo) begin
        rdata_o <= {8'h00, symbol_error_i[7:0]}; // see [RULE17]
      end else if (hit_ctrl) begin
        rdata_o <= {5'h00, ctrl};
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  tx_hold_off_a: assert property (!tx_enable_i |=> // see [RULE8]
    rf_transmit_pin_o == $past(txpin_w.pol))
    else $error("Transmit pin active while transmit disabled.");
  rx_cont_on_a: assert property (!tx_enable_i && full_search_i |=> // see [RULE5]
    receive_enable_pin_o != $past(rxpin_w.pol))
    else $error("Receive power not continuous in full search.");
  rx_polarity_a: assert property (!tx_enable_i && full_search_i |=> // see [RULE6]
    receive_enable_pin_o != rf_receive_pin_o)
    else $error("Receive pins do not follow opposite polarity.");
  demod_on_a: assert property (rx_count_i == demod_on |=> demod_act) // see [RULE1]
    else $error("Demodulator did not turn on at its time.");
  tx_on_a: assert property (tx_count_i == tx_on |=> tx_act) // see [RULE7]
    else $error("Transmit pin window did not open.");
  rx_pin_on_a: assert property (tx_count_i == rx_on |=> rx_act) // see [RULE9]
    else $error("Receive pin window did not open on transmit count.");
  rx_autoinc_a: assert property (rd_i && hit_port && rx_inc && !wr_i // see [RULE13]
    && rx_idx < IDX_BUF_LAST |=> rx_idx == $past(rx_idx) + 6'h01)
    else $error("Receive index did not advance.");
  ctrl_dac_a: assert property (wr_i && hit_ctrl |=> transmit_level_dac_o == $past(wdata_i[3:0])) // see [RULE24]
    else $error("DAC value not taken from control write.");
  timing_read_a: assert property (rd_i && hit_demod || rd_i && hit_txpin // see [RULE3]
    || rd_i && hit_rxpin || rd_i && hit_index |=> rdata_o == 16'h0000)
    else $error("Timing or index slot read nonzero.");
  cv_tx_pulse_c: cover property (tx_enable_i && !rf_transmit_pin_o ##1 rf_transmit_pin_o);
  cv_fifo_full_c: cover property (!wr_ready_o);
  cv_wake_c: cover property (wake_o);
endmodule

// ### rftrb_pkg.sv
// Package with register slots, field positions and timing constants of the peripheral bank.
package rftrb_pkg;

  // ----------------------------------------
  // Slot addressing
  // ----------------------------------------
  localparam logic [1:0] BANK0 = 2'h0;
  localparam logic [1:0] BANK1 = 2'h1;
  localparam logic [1:0] BANK2 = 2'h2;
  localparam logic [2:0] SLOT_DEMOD = 3'h6;
  localparam logic [2:0] SLOT_TXPIN = 3'h7;
  localparam logic [2:0] SLOT_INDEX = 3'h0;
  localparam logic [2:0] SLOT_PORT = 3'h1;
  localparam logic [2:0] SLOT_SYNC = 3'h2;
  localparam logic [2:0] SLOT_CTRL = 3'h6;
  localparam logic [2:0] SLOT_ERRLO = 3'h6;
  localparam logic [2:0] SLOT_RXPIN = 3'h7;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POL_BIT = 15;
  localparam int ON_LSB = 8;
  localparam int RX_INC_BIT = 14;
  localparam int RX_IDX_LSB = 8;
  localparam int TX_INC_BIT = 6;
  localparam int FS_EN_BIT = 10;
  localparam int IRQ0_EN_BIT = 9;
  localparam int IRQ2_EN_BIT = 8;
  localparam int WAKE_LSB = 4;

  // ----------------------------------------
  // Index map and fixed upper time bits
  // ----------------------------------------
  localparam logic [5:0] IDX_BUF_LAST = 6'h23;
  localparam logic [5:0] IDX_VOICE = 6'h24;
  localparam logic [5:0] IDX_MARK_LO = 6'h25;
  localparam logic [5:0] IDX_MARK_HI = 6'h27;
  localparam logic [5:0] IDX_MOD_LO = 6'h28;
  localparam logic [5:0] IDX_MOD_HI = 6'h32;
  localparam logic [1:0] DEMOD_ON_BASE = 2'h1;
  localparam logic [1:0] DEMOD_ON_HAND = 2'h0;
  localparam logic [1:0] DEMOD_OFF_BASE = 2'h2;
  localparam logic [1:0] DEMOD_OFF_HAND = 2'h1;
  localparam logic [1:0] PIN_ON_BASE = 2'h0;
  localparam logic [1:0] PIN_ON_HAND = 2'h1;
  localparam logic [1:0] PIN_OFF_BASE = 2'h1;
  localparam logic [1:0] PIN_OFF_HAND = 2'h2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int DEBOUNCE_BITS = 3;

  typedef struct packed {
    logic pol;
    logic [6:0] on_t;
    logic [6:0] off_t;
  } rftrb_window_s;

  typedef struct packed {
    logic [5:0] idx;
    logic [15:0] data;
  } rftrb_wr_s;

endpackage

// ### rftrb_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides.
module rftrb_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least two.");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  assign in_ready_o = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// ### rftrb_rf_model.sv
// Far-side model that takes buffer writes from the FIFO, with stall and slow modes.
module rftrb_rf_model
  import rftrb_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic stall_i,
  input wire logic slow_i,
  input wire logic wr_valid_i,
  input wire logic [5:0] wr_idx_i,
  input wire logic [15:0] wr_data_i,
  output logic wr_ready_o
);
  logic toggle;
  logic [21:0] got [$];

  // Slow mode accepts only every other cycle.
  assign wr_ready_o = !stall_i && (!slow_i || toggle);

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      toggle <= 1'b0;
      got.delete();
    end else begin
      toggle <= !toggle;
      if (wr_valid_i && wr_ready_o) begin
        got.push_back({wr_idx_i, wr_data_i});
      end
    end
  end
endmodule

// ### tb_rftrb_regs.sv
// Self-checking testbench for the peripheral register banks.
module tb_rftrb_regs
  import rftrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, wr_s, rd_s, handset, tx_en, fsearch, sync_load, wvalid, wready, fifo_rdy;
  logic rxen_pin, rf_receive_pin_pin, rf_transmit_pin_pin, rxn_v, fs_on, i0_on, i2_on, wake, stall, slow;
  logic [1:0] bank, lo, hi, dlo, dhi;
  logic [2:0] slot;
  logic [15:0] wdata, rdata, sync_loop, marker, wdat, v, rdv;
  logic [15:0] mod_w [11];
  logic [15:0] sent [8];
  logic [8:0] rx_cnt, tx_cnt;
  logic [23:0] sym_err;
  logic [5:0] vrx_idx, vtx_init, vrx_init, widx, rxn_idx;
  logic [3:0] vrx_nib, rxn, p0n, p0dir, dac;
  logic [3:0] exp_rx [36];
  logic [4:0] zl [15] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h08,
    5'h0B, 5'h0C, 5'h0D, 5'h0F, 5'h16, 5'h17, 5'h18};
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 32'h8562;

  rftrb_regs #(.BIT_DIV(4), .FIFO_DEPTH(8)) uut (
    .ref_clk_i(clk), .srst_i(srst), .bank_i(bank), .slot_i(slot), .wr_i(wr_s), .rd_i(rd_s),
    .wdata_i(wdata), .rdata_o(rdata), .handset_i(handset), .tx_enable_i(tx_en),
    .full_search_i(fsearch), .rx_count_i(rx_cnt), .tx_count_i(tx_cnt),
    .receive_enable_pin_o(rxen_pin), .rf_receive_pin_o(rf_receive_pin_pin), .rf_transmit_pin_o(rf_transmit_pin_pin),
    .symbol_error_i(sym_err), .sync_loop_o(sync_loop), .sync_loop_load_o(sync_load),
    .voice_rx_idx_i(vrx_idx), .voice_rx_nibble_o(vrx_nib), .voice_tx_index_init_o(vtx_init),
    .voice_rx_index_init_o(vrx_init), .nibble_marker_o(marker),
    .modulator_frequency_words_o(mod_w), .wr_valid_o(wvalid), .wr_ready_i(wready),
    .wr_idx_o(widx), .wr_data_o(wdat), .wr_ready_o(fifo_rdy), .rx_nibble_i(rxn),
    .rx_nibble_valid_i(rxn_v), .rx_nibble_idx_i(rxn_idx), .frame_start_irq_on_o(fs_on),
    .ext_irq_zero_on_o(i0_on), .ext_irq_two_on_o(i2_on), .port_zero_n_i(p0n),
    .port_zero_dir_i(p0dir), .wake_o(wake), .transmit_level_dac_o(dac));
  rftrb_rf_model far (.ref_clk_i(clk), .srst_i(srst), .stall_i(stall), .slow_i(slow),
    .wr_valid_i(wvalid), .wr_idx_i(widx), .wr_data_i(wdat), .wr_ready_o(wready));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] b, input logic [2:0] s, input logic [15:0] d);
    @(negedge clk);
    bank = b;
    slot = s;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  task automatic rd(input logic [1:0] b, input logic [2:0] s, output logic [15:0] d);
    @(negedge clk);
    bank = b;
    slot = s;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    d = rdata;
  endtask
  task automatic at_count(input logic [8:0] rc, input logic [8:0] tc);
    @(negedge clk);
    rx_cnt = rc;
    tx_cnt = tc;
    repeat (2) @(negedge clk);
  endtask
  task automatic wait_for(input logic w);
    for (int n = 0; n < 200 && wake !== w; n++) @(negedge clk);
    chk(wake, w);
  endtask
  task automatic final_report;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      final_report;
    end
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    {wr_s, rd_s, handset, fsearch, rxn_v, stall, slow} = '0;
    tx_en = 1'b1;
    {bank, slot, wdata, rx_cnt, tx_cnt, sym_err, vrx_idx, rxn, rxn_idx, p0dir} = '0;
    p0n = 4'hF;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    chk({rxen_pin, rf_receive_pin_pin, rf_transmit_pin_pin}, 3'b010);
    for (int h = 0; h < 2; h++) begin
      handset = h[0];
      lo = h[0] ? 2'b01 : 2'b00;
      hi = h[0] ? 2'b10 : 2'b01;
      dlo = h[0] ? 2'b00 : 2'b01;
      dhi = h[0] ? 2'b01 : 2'b10;
      wr(2'h2, 3'h7, 16'h1020);
      wr(2'h0, 3'h7, 16'h1020);
      wr(2'h2, 3'h6, 16'h3040);
      at_count(9'h000, {lo, 7'h10});
      chk(rf_transmit_pin_pin, 1'b1);
      chk(rf_receive_pin_pin, 1'b0);
      at_count(9'h000, {hi, 7'h20});
      chk(rf_transmit_pin_pin, 1'b0);
      chk(rf_receive_pin_pin, 1'b1);
      at_count({dlo, 7'h30}, {hi, 7'h20});
      chk(rxen_pin, 1'b1);
      at_count({dhi, 7'h40}, {hi, 7'h20});
      chk(rxen_pin, 1'b0);
    end
    wr(2'h2, 3'h7, 16'h9020);
    @(negedge clk);
    chk(rf_transmit_pin_pin, 1'b1);
    wr(2'h0, 3'h7, 16'h9020);
    @(negedge clk);
    chk({rf_receive_pin_pin, rxen_pin}, 2'b01);
    wr(2'h2, 3'h7, 16'h1020);
    wr(2'h0, 3'h7, 16'h1020);
    tx_en = 1'b0;
    at_count(9'h000, 9'h090);
    chk(rf_transmit_pin_pin, 1'b0);
    fsearch = 1'b1;
    repeat (3) @(negedge clk);
    chk(rxen_pin, 1'b1);
    chk(rf_receive_pin_pin, 1'b0);
    fsearch = 1'b0;
    tx_en = 1'b1;
    $display("test pins done");
    rd(2'h1, 3'h6, rdv);
    chk(rdv, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      v = (i == 4) ? 16'hFFFF : 16'($random(seed));
      wr(2'h1, 3'h6, v);
      chk(fs_on, v[10]);
      chk({i0_on, i2_on}, v[9:8]);
      chk(dac, v[3:0]);
      rd(2'h1, 3'h6, rdv);
      chk(rdv, v & 16'h07FF);
    end
    foreach (zl[i]) begin
      rd(zl[i][4:3], zl[i][2:0], rdv);
      chk(rdv, 16'h0000);
    end
    $display("test control done");
    sym_err = 24'($random(seed));
    rd(2'h1, 3'h2, rdv);
    chk(rdv, sym_err[23:8]);
    rd(2'h0, 3'h6, rdv);
    chk(rdv, {8'h00, sym_err[7:0]});
    v = 16'($random(seed));
    wr(2'h1, 3'h2, v);
    chk({sync_load, sync_loop}, {1'b1, v});
    @(negedge clk);
    chk(sync_load, 1'b0);
    $display("test sync done");
    for (int i = 0; i < 36; i++) begin
      @(negedge clk);
      exp_rx[i] = 4'($random(seed));
      rxn_idx = i[5:0];
      rxn = exp_rx[i];
      rxn_v = 1'b1;
    end
    @(negedge clk);
    rxn_v = 1'b0;
    wr(2'h1, 3'h0, 16'h6100);
    for (int i = 0; i < 4; i++) begin
      rd(2'h1, 3'h1, rdv);
      chk(rdv, {12'h000, exp_rx[(i < 3) ? 33 + i : 35]});
    end
    wr(2'h1, 3'h0, 16'h0500);
    for (int i = 0; i < 2; i++) begin
      rd(2'h1, 3'h1, rdv);
      chk(rdv, {12'h000, exp_rx[5]});
    end
    vrx_idx = 6'h07;
    repeat (2) @(negedge clk);
    chk(vrx_nib, exp_rx[7]);
    $display("test rx buffer done");
    stall = 1'b1;
    wr(2'h1, 3'h0, 16'h0040);
    for (int i = 0; i < 8; i++) begin
      sent[i] = 16'($random(seed));
      wr(2'h1, 3'h1, sent[i]);
    end
    chk(fifo_rdy, 1'b0);
    wr(2'h1, 3'h1, 16'hDEAD);
    stall = 1'b0;
    slow = 1'b1;
    for (int n = 0; n < 100 && far.got.size() < 8; n++) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      chk(far.got[i], {i[5:0], sent[i]});
    end
    wr(2'h1, 3'h1, 16'h5A5A);
    for (int n = 0; n < 100 && far.got.size() < 9; n++) @(negedge clk);
    chk(far.got[8], {6'h08, 16'h5A5A});
    wr(2'h1, 3'h0, 16'h0024);
    wr(2'h1, 3'h1, 16'h1A2B);
    chk({vtx_init, vrx_init}, 12'h6AB);
    wr(2'h1, 3'h0, 16'h0027);
    wr(2'h1, 3'h1, 16'hC3C3);
    chk(marker, 16'hC3C3);
    wr(2'h1, 3'h0, 16'h0068);
    for (int k = 0; k < 11; k++) begin
      v = 16'($random(seed));
      wr(2'h1, 3'h1, v);
      chk(mod_w[k], v);
    end
    repeat (4) @(negedge clk);
    chk(24'(far.got.size()), 24'h000009);
    $display("test tx buffer done");
    wr(2'h1, 3'h6, 16'h0010);
    p0n = 4'hE;
    wait_for(1'b1);
    p0n = 4'hF;
    repeat (3) @(negedge clk);
    chk(wake, 1'b1);
    wait_for(1'b0);
    p0dir = 4'h1;
    p0n = 4'hE;
    repeat (60) @(negedge clk);
    chk(wake, 1'b0);
    $display("test wake done");
    final_report;
  end
endmodule
